// file: core/tw_pkg.sv
// package: register map, field positions, status codes and sequencer states
package tw_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------------
	localparam int         ADR_W     = 4;
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STAT_ADDR = 4'h4;
	localparam logic [3:0] DATA_ADDR = 4'h8;
	localparam logic [3:0] RATE_ADDR = 4'hC;

	// ------------------------------------------------------------------
	// two_wire_control field positions and masks
	// ------------------------------------------------------------------
	localparam int         FLAG_BIT     = 7;
	localparam int         ACK_EN_BIT   = 6;
	localparam int         START_BIT    = 5;
	localparam int         STOP_BIT     = 4;
	localparam int         WCOL_BIT     = 3;
	localparam int         EN_BIT       = 2;
	localparam logic [7:0] CTRL_WR_MASK = 8'h75;
	localparam logic [7:0] WCOL_MASK    = 8'h08;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'hFF;
	localparam logic [7:0] RATE_RST = 8'h18;
	localparam logic [1:0] PRE_RST  = 2'h0;

	// ------------------------------------------------------------------
	// bus_status_code values, prescaler bits zero
	// ------------------------------------------------------------------
	localparam logic [7:0] CODE_START   = 8'h08;
	localparam logic [7:0] CODE_RSTART  = 8'h10;
	localparam logic [7:0] CODE_WA_ACK  = 8'h18;
	localparam logic [7:0] CODE_WA_NACK = 8'h20;
	localparam logic [7:0] CODE_WD_ACK  = 8'h28;
	localparam logic [7:0] CODE_WD_NACK = 8'h30;
	localparam logic [7:0] CODE_ARB     = 8'h38;
	localparam logic [7:0] CODE_RA_ACK  = 8'h40;
	localparam logic [7:0] CODE_RA_NACK = 8'h48;
	localparam logic [7:0] CODE_RD_ACK  = 8'h50;
	localparam logic [7:0] CODE_RD_NACK = 8'h58;
	localparam logic [7:0] CODE_IDLE    = 8'hF8;

	// ------------------------------------------------------------------
	// quarter-bit phases and sequencer states
	// ------------------------------------------------------------------
	localparam logic [1:0] PH_DRIVE  = 2'h0;
	localparam logic [1:0] PH_RISE   = 2'h1;
	localparam logic [1:0] PH_SAMPLE = 2'h2;
	localparam logic [1:0] PH_FALL   = 2'h3;

	typedef enum logic [8:0] {
		TW_IDLE      = 9'h001,
		TW_WAIT_FREE = 9'h002,
		TW_START     = 9'h004,
		TW_HOLD      = 9'h008,
		TW_TX        = 9'h010,
		TW_GET_ACK   = 9'h020,
		TW_RX        = 9'h040,
		TW_PUT_ACK   = 9'h080,
		TW_STOP      = 9'h100
	} tw_state_t;

endpackage : tw_pkg

// file: core/tw_link_if.sv
// interface: synchronised line levels and bit-rate ticks inside the block
`timescale 1ns/1ns
`default_nettype none
interface tw_link_if;
	logic       scl;  // clock line, synchronised
	logic       sda;  // data line, synchronised
	logic       busy; // start seen, no stop yet
	logic       tick; // quarter-bit pulse
	logic [1:0] pre;  // prescaler select
	logic [7:0] rate; // bit-rate divider

	modport mon  (output scl, output sda, output busy);
	modport gen  (input pre, input rate, output tick);
	modport core (input scl, input sda, input busy, input tick,
		output pre, output rate);
endinterface : tw_link_if
`default_nettype wire

// file: core/tw_line_monitor.sv
// module: pin synchronisers and bus-busy tracking from start/stop conditions
`timescale 1ns/1ns
`default_nettype none
module tw_line_monitor (
	input  wire logic sys_clk_in, // system clock
	input  wire logic rst_in,     // sync reset, active high
	input  wire logic scl_in,     // clock pin level
	input  wire logic sda_in,     // data pin level
	tw_link_if.mon    lnk         // synchronised lines
);
	import tw_pkg::*;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] prev;
		logic       busy;
	} tw_mon_t;

	tw_mon_t st;
	tw_mon_t next_st;

	always_comb begin
		next_st = st;
		next_st.s1 = {scl_in, sda_in};
		next_st.s2 = st.s1;
		next_st.prev = st.s2;
		// data edge while clock stays high marks start (fall) or stop (rise)
		if (st.s2[1] && st.prev[1] && st.prev[0] && !st.s2[0]) begin
			next_st.busy = 1'b1;
		end else if (st.s2[1] && st.prev[1] && !st.prev[0] && st.s2[0]) begin
			next_st.busy = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lnk.scl  = st.s2[1];
	assign lnk.sda  = st.s2[0];
	assign lnk.busy = st.busy;
endmodule : tw_line_monitor
`default_nettype wire

// file: core/tw_tick_gen.sv
// module: quarter-bit tick generator from bit-rate divider and prescaler
`timescale 1ns/1ns
`default_nettype none
module tw_tick_gen (
	input  wire logic sys_clk_in, // system clock
	input  wire logic rst_in,     // sync reset, active high
	tw_link_if.gen    lnk         // divider in, tick out
);
	import tw_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} tw_tick_t;

	tw_tick_t    st;
	tw_tick_t    next_st;
	logic [15:0] span;

	always_comb begin
		// quarter period = (rate + 1) * 4^pre system clocks
		span = 16'(({8'h00, lnk.rate} + 16'h0001) << {lnk.pre, 1'b0});
		next_st.tick = 1'b0;
		next_st.cnt = st.cnt + 16'h0001;
		// >= so that a divider lowered mid-count cannot strand the counter
		if (st.cnt >= span - 16'h0001) begin
			next_st.cnt = 16'h0000;
			next_st.tick = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lnk.tick = st.tick;
endmodule : tw_tick_gen
`default_nettype wire

// file: core/tw_master_rx.sv
// module: two-wire master receiver with wishbone registers and bit engine
// Summary of operation
// R01: master operation begins only after this block has sent a START.
// R02: direction bit of the address after START picks transmit or receive.
// R03: software masks prescaler bits to zero before comparing status codes.
// R04: software requests START with flag, start and enable at one.
// R05: START is generated only once the bus is seen free.
// R06: after START the flag is set and status reads 0x08.
// R07: software loads read address, then clears flag with start/stop zero.
// R08: after read address and its ack bit, flag sets with 0x38/0x40/0x48.
// R09: received byte sits in the data register while flag is set with 0x50/0x58.
// R10: software clears ack enable before the last byte to send NACK.
// R11: flag cleared with stop alone sends STOP, then stop bit self-clears.
// R12: flag cleared with start and stop sends STOP then START.
// R13: repeated START reports 0x10 and keeps the bus.
// R14: in 0x08/0x10 read address receives; write address in 0x10 transmits.
// R15: arbitration lost reports 0x38 and releases bus; clearing flag idles.
// R16: in 0x38 clearing flag with start set retries START when bus free.
// R17: in 0x40/0x50 clearing flag receives a byte, ACK per ack enable.
// R18: read address not acknowledged reports 0x48; stop or restart follow.
// R19: byte received with ACK returned reports 0x50, byte stays readable.
// R20: byte received with NACK returned reports 0x58.
// R21: clock line is held low while the flag is set; the code releases it when it posts 0x38.
`timescale 1ns/1ns
`default_nettype none
module tw_master_rx (
	input  wire logic                     sys_clk_in, // system clock
	input  wire logic                     rst_in,     // sync reset
	input  wire logic                     wb_cyc_in,  // bus cycle
	input  wire logic                     wb_stb_in,  // strobe
	input  wire logic                     wb_we_in,   // write enable
	input  wire logic [tw_pkg::ADR_W-1:0] wb_adr_in,  // byte address
	input  wire logic [3:0]               wb_sel_in,  // byte lanes
	input  wire logic [31:0]              wb_dat_in,  // write data
	output logic      [31:0]              wb_dat_out, // read data
	output logic                          wb_ack_out, // acknowledge
	input  wire logic                     scl_in,     // clock pin level
	output logic                          scl_out,    // clock pin drive
	output logic                          scl_oe_out, // clock pin enable
	input  wire logic                     sda_in,     // data pin level
	output logic                          sda_out,    // data pin drive
	output logic                          sda_oe_out  // data pin enable
);
	import tw_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		tw_state_t   state;
		logic [1:0]  phase;
		logic [2:0]  bitcnt;
		logic [7:0]  shift;
		logic [7:0]  ctrl;
		logic [7:0]  data;
		logic [7:0]  code;
		logic [1:0]  pre;
		logic [7:0]  rate;
		logic        rx_mode;
		logic        addr_phase;
		logic        rep;
		logic        lost;
		logic        nack;
		logic        scl_oe;
		logic        sda_oe;
		logic        ack;
		logic [31:0] rdat;
	} tw_core_t;

	tw_core_t   st;
	tw_core_t   next_st;
	logic [7:0] rd;
	logic       wr;
	logic       go;
	logic       post;
	logic       lose_arb;
	logic [7:0] post_code;

	tw_link_if lnk ();

	tw_line_monitor u_mon (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.scl_in     (scl_in),
		.sda_in     (sda_in),
		.lnk        (lnk)
	);

	tw_tick_gen u_tick (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.lnk        (lnk)
	);

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		next_st = st;
		post = 1'b0;
		lose_arb = 1'b0;
		post_code = CODE_IDLE;
		rd = 8'h00;
		// the sample phase waits for the clock line to read high, so a
		// slave stretching the clock simply slows the engine down
		go = lnk.tick && (st.phase != PH_SAMPLE || lnk.scl);

		// bus slave: answer one cycle after the request, write on ack
		next_st.ack = wb_cyc_in && wb_stb_in && !st.ack;
		if (wb_adr_in == CTRL_ADDR) begin
			rd = st.ctrl;
		end else if (wb_adr_in == STAT_ADDR) begin
			rd = {st.code[7:3], 1'b0, st.pre};
		end else if (wb_adr_in == DATA_ADDR) begin
			rd = st.data;
		end else if (wb_adr_in == RATE_ADDR) begin
			rd = st.rate;
		end
		if (next_st.ack) begin
			next_st.rdat = {24'h000000, rd};
		end
		wr = wb_cyc_in && wb_stb_in && wb_we_in && st.ack && wb_sel_in[0];
		if (wr) begin
			if (wb_adr_in == CTRL_ADDR) begin
				next_st.ctrl = (st.ctrl & WCOL_MASK)
					| (wb_dat_in[7:0] & CTRL_WR_MASK);
				// writing one to the flag clears it
				next_st.ctrl[FLAG_BIT] = st.ctrl[FLAG_BIT]
					& ~wb_dat_in[FLAG_BIT];
			end else if (wb_adr_in == STAT_ADDR) begin
				next_st.pre = wb_dat_in[1:0];
			end else if (wb_adr_in == DATA_ADDR) begin
				// the byte may only change while the engine is parked
				if (st.ctrl[FLAG_BIT]) begin
					next_st.data = wb_dat_in[7:0];
					next_st.ctrl[WCOL_BIT] = 1'b0;
				end else begin
					next_st.ctrl[WCOL_BIT] = 1'b1;
				end
			end else if (wb_adr_in == RATE_ADDR) begin
				next_st.rate = wb_dat_in[7:0];
			end
		end

		// sequencer
		if (!st.ctrl[EN_BIT]) begin
			next_st.state = TW_IDLE;
			next_st.phase = PH_DRIVE;
			next_st.scl_oe = 1'b0;
			next_st.sda_oe = 1'b0;
			next_st.lost = 1'b0;
		end else begin
			if (go && st.state != TW_IDLE && st.state != TW_WAIT_FREE
				&& st.state != TW_HOLD) begin
				next_st.phase = st.phase + 2'h1;
			end
			case (st.state)
				TW_IDLE: begin
					next_st.scl_oe = 1'b0;
					next_st.sda_oe = 1'b0;
					if (st.ctrl[START_BIT] && !st.ctrl[FLAG_BIT]) begin
						next_st.state = TW_WAIT_FREE; // R01
					end
				end
				TW_WAIT_FREE: begin
					if (!lnk.busy) begin
						next_st.state = TW_START; // R05
						next_st.phase = PH_DRIVE;
						next_st.rep = 1'b0;
					end
				end
				TW_START: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: next_st.sda_oe = 1'b0;
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: next_st.sda_oe = 1'b1;
							default: begin
								post = 1'b1;
								post_code = st.rep ? CODE_RSTART // R13
									: CODE_START; // R06
							end
						endcase
					end
				end
				TW_HOLD: begin
					if (!st.ctrl[FLAG_BIT]) begin
						next_st.phase = PH_DRIVE;
						next_st.bitcnt = 3'h0;
						if (st.lost) begin
							next_st.lost = 1'b0;
							next_st.code = CODE_IDLE;
							next_st.state = st.ctrl[START_BIT] // R16
								? TW_WAIT_FREE : TW_IDLE; // R15
						end else if (st.ctrl[STOP_BIT]) begin
							next_st.state = TW_STOP; // R11 R18 R20
						end else if (st.ctrl[START_BIT]) begin
							next_st.state = TW_START; // R13 R18 R20
							next_st.rep = 1'b1;
						end else if (st.code == CODE_START
							|| st.code == CODE_RSTART) begin
							next_st.state = TW_TX; // R14
							next_st.shift = st.data;
							next_st.rx_mode = st.data[0]; // R02
							next_st.addr_phase = 1'b1;
						end else if (st.code == CODE_RA_ACK
							|| st.code == CODE_RD_ACK) begin
							next_st.state = TW_RX; // R17
							next_st.addr_phase = 1'b0;
						end else if (st.code == CODE_WA_ACK
							|| st.code == CODE_WA_NACK
							|| st.code == CODE_WD_ACK
							|| st.code == CODE_WD_NACK) begin
							next_st.state = TW_TX;
							next_st.shift = st.data;
							next_st.addr_phase = 1'b0;
						end
					end
				end
				TW_TX: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: next_st.sda_oe = !st.shift[7];
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: begin
								// a released line read low: another master won
								if (!st.sda_oe && !lnk.sda) begin
									lose_arb = 1'b1; // R15
								end
							end
							default: begin
								next_st.scl_oe = 1'b1;
								next_st.shift = {st.shift[6:0], 1'b0};
								next_st.bitcnt = st.bitcnt + 3'h1;
								if (st.bitcnt == 3'h7) begin
									next_st.state = TW_GET_ACK;
								end
							end
						endcase
					end
				end
				TW_GET_ACK: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: next_st.sda_oe = 1'b0;
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: next_st.nack = lnk.sda;
							default: begin
								post = 1'b1;
								if (!st.addr_phase) begin
									post_code = st.nack ? CODE_WD_NACK
										: CODE_WD_ACK;
								end else if (st.rx_mode) begin
									post_code = st.nack ? CODE_RA_NACK // R18
										: CODE_RA_ACK; // R08
								end else begin
									post_code = st.nack ? CODE_WA_NACK
										: CODE_WA_ACK; // R14
								end
							end
						endcase
					end
				end
				TW_RX: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: next_st.sda_oe = 1'b0;
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: next_st.shift = {st.shift[6:0], lnk.sda};
							default: begin
								next_st.scl_oe = 1'b1;
								next_st.bitcnt = st.bitcnt + 3'h1;
								if (st.bitcnt == 3'h7) begin
									next_st.data = st.shift; // R09
									next_st.state = TW_PUT_ACK;
								end
							end
						endcase
					end
				end
				TW_PUT_ACK: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: begin
								next_st.sda_oe = st.ctrl[ACK_EN_BIT]; // R17
								next_st.nack = !st.ctrl[ACK_EN_BIT];
							end
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: begin
								if (!st.sda_oe && !lnk.sda) begin
									lose_arb = 1'b1; // R15
								end
							end
							default: begin
								post = 1'b1;
								post_code = st.nack ? CODE_RD_NACK // R20
									: CODE_RD_ACK; // R19
							end
						endcase
					end
				end
				TW_STOP: begin
					if (go) begin
						case (st.phase)
							PH_DRIVE: next_st.sda_oe = 1'b1;
							PH_RISE: next_st.scl_oe = 1'b0;
							PH_SAMPLE: next_st.sda_oe = 1'b0;
							default: begin
								next_st.ctrl[STOP_BIT] = 1'b0; // R11
								next_st.code = CODE_IDLE;
								// start still set: stop then start
								next_st.state = st.ctrl[START_BIT] // R12
									? TW_WAIT_FREE : TW_IDLE;
							end
						endcase
					end
				end
				default: next_st.state = TW_IDLE;
			endcase
		end

		if (lose_arb) begin
			next_st.lost = 1'b1;
			post = 1'b1;
			post_code = CODE_ARB; // R15
		end
		// hardware set is applied last so it beats a same-cycle clear
		if (post) begin
			next_st.ctrl[FLAG_BIT] = 1'b1;
			next_st.code = post_code;
			next_st.state = TW_HOLD;
			next_st.phase = PH_DRIVE;
			next_st.bitcnt = 3'h0;
			// hold our data level while the clock falls; releasing races it
			next_st.sda_oe = st.sda_oe && !lose_arb;
			next_st.scl_oe = !lose_arb; // R21
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.state <= TW_IDLE;
			st.ctrl <= CTRL_RST;
			st.data <= DATA_RST;
			st.code <= CODE_IDLE;
			st.pre <= PRE_RST;
			st.rate <= RATE_RST;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign lnk.pre    = st.pre;
	assign lnk.rate   = st.rate;
	assign wb_dat_out = st.rdat;
	assign wb_ack_out = st.ack;
	// open drain: only ever pull low, enable decides
	assign scl_out    = 1'b0;
	assign sda_out    = 1'b0;
	assign scl_oe_out = st.scl_oe;
	assign sda_oe_out = st.sda_oe;
endmodule : tw_master_rx
`default_nettype wire

// file: testbench/tw_master_rx_assertions.sv
// checker: port-level timing rules of the two-wire master receiver
`timescale 1ns/1ns
`default_nettype none
module tw_master_rx_assertions
	import tw_pkg::*;
(
	input wire logic                     sys_clk_in, // system clock
	input wire logic                     rst_in,     // sync reset
	input wire logic                     wb_cyc_in,  // bus cycle
	input wire logic                     wb_stb_in,  // strobe
	input wire logic                     wb_we_in,   // write enable
	input wire logic [tw_pkg::ADR_W-1:0] wb_adr_in,  // byte address
	input wire logic [3:0]               wb_sel_in,  // byte lanes
	input wire logic [31:0]              wb_dat_in,  // write data
	input wire logic [31:0]              wb_dat_out, // read data
	input wire logic                     wb_ack_out, // acknowledge
	input wire logic                     scl_in,     // clock line level
	input wire logic                     scl_out,    // clock pin drive
	input wire logic                     scl_oe_out, // clock pin enable
	input wire logic                     sda_in,     // data line level
	input wire logic                     sda_out,    // data pin drive
	input wire logic                     sda_oe_out  // data pin enable
);
	logic ctl_off_wr;
	logic unmapped_rd;

	// the request is still held in the ack cycle, so no history is needed
	assign ctl_off_wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_sel_in[0]
		&& wb_adr_in == CTRL_ADDR && !wb_dat_in[EN_BIT];
	assign unmapped_rd = wb_cyc_in && wb_stb_in && !wb_we_in
		&& wb_adr_in[1:0] != 2'h0;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held longer than one cycle");
	a_ack_latency: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out) else $error("ack missing one cycle after request");
	a_ack_cause: assert property (wb_ack_out |-> $past(wb_stb_in))
		else $error("ack without a strobe");
	a_rdat_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_unmapped_read: assert property (wb_ack_out && unmapped_rd
		|-> wb_dat_out == 32'h0) else $error("unmapped read not zero");
	a_reset_quiet: assert property ($past(rst_in)
		|-> !wb_ack_out && !scl_oe_out && !sda_oe_out)
		else $error("outputs active right after reset");
	a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("open-drain drive value not low");
	a_start_shape: assert property (
		$rose(sda_oe_out) && !scl_oe_out && scl_in |-> ##[1:120] scl_oe_out)
		else $error("clock not pulled low after start");
	a_stop_release: assert property (
		$fell(sda_oe_out) && !$past(scl_oe_out) && scl_in
		|=> !scl_oe_out [*2]) else $error("clock pulled low right after stop");
	a_disable_release: assert property (wb_ack_out && ctl_off_wr
		|-> ##[1:3] (!scl_oe_out && !sda_oe_out))
		else $error("pins not released on disable");

	c_start: cover property ($rose(sda_oe_out) && !scl_oe_out && scl_in);
	c_stop: cover property ($fell(sda_oe_out) && !$past(scl_oe_out) && scl_in);
	c_unmapped: cover property (wb_ack_out && unmapped_rd);
endmodule : tw_master_rx_assertions
`default_nettype wire

// file: testbench/tw_slave_model.sv
// partner: behavioural slave transmitter on the two-wire bus
`timescale 1ns/1ns
`default_nettype none
module tw_slave_model #(
	parameter logic [6:0] ADDR       = 7'h2A, // own address
	parameter int         STRETCH_NS = 0      // clock hold while driving the address ack
) (
	input  wire logic scl_in,     // clock line level
	input  wire logic sda_in,     // data line level
	output logic      scl_oe_out, // high pulls clock line low
	output logic      sda_oe_out  // high pulls data line low
);
	logic [7:0] sh;
	logic [7:0] tx;
	logic       nack;
	int         k;

	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
		forever begin
			@(negedge sda_in iff scl_in === 1'b1);
			for (int i = 0; i < 8; i++) begin
				@(posedge scl_in);
				sh = {sh[6:0], sda_in};
			end
			@(negedge scl_in);
			// answer only our own address in the read direction
			if (sh[7:1] == ADDR && sh[0]) begin
				sda_oe_out = 1'b1;
				if (STRETCH_NS > 0) begin
					scl_oe_out = 1'b1;
					#(STRETCH_NS);
					scl_oe_out = 1'b0;
				end
				k = 0;
				nack = 1'b0;
				while (!nack) begin
					tx = 8'hA5 + 8'(k) * 8'h11;
					for (int i = 7; i >= 0; i--) begin
						@(negedge scl_in);
						sda_oe_out = !tx[i];
					end
					@(negedge scl_in);
					sda_oe_out = 1'b0;
					@(posedge scl_in);
					nack = sda_in;
					k++;
				end
			end
		end
	end
endmodule : tw_slave_model
`default_nettype wire

// file: testbench/tw_master_rx_tb.sv
// testbench: register and receive scenarios against a slave model
`timescale 1ns/1ns
`default_nettype none
`define check_eq(nm, ex, got) begin \
	n_tests++; \
	if ((got) !== (ex)) begin \
		err_total++; \
		$display("ERROR %s exp %h got %h", nm, ex, got); \
	end \
end
module tw_master_rx_tb;
	import tw_pkg::*;
	localparam logic [6:0] SLV = 7'h2A;
	logic        sys_clk_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic        wb_cyc_in  = 1'b0;
	logic        wb_stb_in  = 1'b0;
	logic        wb_we_in   = 1'b0;
	logic [3:0]  wb_adr_in  = 4'h0;
	logic [3:0]  wb_sel_in  = 4'h0;
	logic [31:0] wb_dat_in  = 32'h0;
	logic [31:0] wb_dat_out;
	logic        wb_ack_out;
	logic        scl_oe_out;
	logic        sda_oe_out;
	logic        slv_scl_oe;
	logic        slv_sda_oe;
	logic        arb_oe     = 1'b0; // a rival master pulling data low
	wire logic   scl_w;
	wire logic   sda_w;
	logic [7:0]  rv;
	int          err_total  = 0;
	int          n_tests    = 0;

	// both lines have pull-ups: high unless some party pulls low
	assign scl_w = !(scl_oe_out | slv_scl_oe);
	assign sda_w = !(sda_oe_out | slv_sda_oe | arb_oe);

	always #50 sys_clk_in = ~sys_clk_in;

	tw_master_rx i_dut (
		.sys_clk_in (sys_clk_in), .rst_in (rst_in),
		.wb_cyc_in (wb_cyc_in), .wb_stb_in (wb_stb_in),
		.wb_we_in (wb_we_in), .wb_adr_in (wb_adr_in),
		.wb_sel_in (wb_sel_in), .wb_dat_in (wb_dat_in),
		.wb_dat_out (wb_dat_out), .wb_ack_out (wb_ack_out),
		.scl_in (scl_w), .scl_out (), .scl_oe_out (scl_oe_out),
		.sda_in (sda_w), .sda_out (), .sda_oe_out (sda_oe_out)
	);

	tw_slave_model #(.ADDR(SLV), .STRETCH_NS(1500)) i_slv (
		.scl_in (scl_w), .sda_in (sda_w),
		.scl_oe_out (slv_scl_oe), .sda_oe_out (slv_sda_oe)
	);

	task automatic wb(input logic [3:0] a, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in  <= w;
		wb_adr_in <= a;
		wb_sel_in <= 4'hF;
		wb_dat_in <= {24'h0, d};
		do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
		q = wb_dat_out[7:0];
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
	endtask : wb

	// write control, then poll until the flag is up and judge the code
	task automatic step(input logic [7:0] ctl, input logic [7:0] code);
		int n;
		wb(CTRL_ADDR, 1'b1, ctl, rv);
		n = 0;
		do begin
			wb(CTRL_ADDR, 1'b0, 8'h00, rv);
			n++;
		end while (rv[FLAG_BIT] !== 1'b1 && n < 400);
		`check_eq("flag set", 1'b1, rv[FLAG_BIT])
		wb(STAT_ADDR, 1'b0, 8'h00, rv);
		`check_eq("status", code, rv & 8'hF8)
	endtask : step

	task automatic t_regs;
		logic [7:0] ex [4] = '{CTRL_RST, CODE_IDLE, DATA_RST, RATE_RST};
		for (int i = 0; i < 4; i++) begin
			wb(4'(4 * i), 1'b0, 8'h00, rv);
			`check_eq("reset value", ex[i], rv)
		end
		`check_eq("lines idle", 2'b11, {scl_w, sda_w})
		wb(4'h6, 1'b1, 8'h5A, rv);
		wb(4'h6, 1'b0, 8'h00, rv);
		`check_eq("unmapped", 8'h00, rv)
		wb(DATA_ADDR, 1'b1, 8'h55, rv);
		wb(CTRL_ADDR, 1'b0, 8'h00, rv);
		`check_eq("collision", WCOL_MASK, rv)
		wb(DATA_ADDR, 1'b0, 8'h00, rv);
		`check_eq("data kept", DATA_RST, rv)
		wb(STAT_ADDR, 1'b1, 8'h03, rv);
		wb(STAT_ADDR, 1'b0, 8'h00, rv);
		`check_eq("prescaler", CODE_IDLE | 8'h03, rv)
		wb(STAT_ADDR, 1'b1, 8'h00, rv);
		wb(CTRL_ADDR, 1'b1, 8'h00, rv);
		// rate 1 gives an 800 ns bit clock
		wb(RATE_ADDR, 1'b1, 8'h01, rv);
		wb(RATE_ADDR, 1'b0, 8'h00, rv);
		`check_eq("rate", 8'h01, rv)
		$display("done: registers");
	endtask : t_regs

	task automatic t_receive;
		step(8'hA4, CODE_START);
		`check_eq("clock held", 1'b1, scl_oe_out)
		wb(DATA_ADDR, 1'b1, {SLV, 1'b1}, rv);
		step(8'hC4, CODE_RA_ACK);
		step(8'hC4, CODE_RD_ACK);
		wb(DATA_ADDR, 1'b0, 8'h00, rv);
		`check_eq("byte 0", 8'hA5, rv)
		step(8'h84, CODE_RD_NACK);
		wb(DATA_ADDR, 1'b0, 8'h00, rv);
		`check_eq("byte 1", 8'hB6, rv)
		step(8'hB4, CODE_START);
		wb(CTRL_ADDR, 1'b0, 8'h00, rv);
		`check_eq("stop bit", 1'b0, rv[STOP_BIT])
		$display("done: receive");
	endtask : t_receive

	task automatic t_restart;
		int n;
		wb(DATA_ADDR, 1'b1, {7'h11, 1'b1}, rv);
		step(8'h84, CODE_RA_NACK);
		step(8'hA4, CODE_RSTART);
		wb(DATA_ADDR, 1'b1, {SLV, 1'b1}, rv);
		step(8'h84, CODE_RA_ACK);
		step(8'h84, CODE_RD_NACK);
		wb(DATA_ADDR, 1'b0, 8'h00, rv);
		`check_eq("byte 0", 8'hA5, rv)
		wb(CTRL_ADDR, 1'b1, 8'h94, rv);
		n = 0;
		do begin
			wb(CTRL_ADDR, 1'b0, 8'h00, rv);
			n++;
		end while (rv[STOP_BIT] !== 1'b0 && n < 400);
		`check_eq("stop bit", 1'b0, rv[STOP_BIT])
		`check_eq("lines free", 2'b11, {scl_w, sda_w})
		$display("done: restart");
	endtask : t_restart

	// the rival holds data low through our first address bit, a one
	task automatic t_arb;
		step(8'hA4, CODE_START);
		wb(DATA_ADDR, 1'b1, 8'hA5, rv);
		arb_oe <= 1'b1;
		step(8'h84, CODE_ARB);
		`check_eq("released", 2'b00, {scl_oe_out, sda_oe_out})
		// rival lets go with the clock high: a stop, so the bus is free
		arb_oe <= 1'b0;
		step(8'hA4, CODE_START);
		wb(CTRL_ADDR, 1'b1, 8'h00, rv);
		wb(CTRL_ADDR, 1'b0, 8'h00, rv);
		`check_eq("disabled", 2'b11, {scl_w, sda_w})
		$display("done: arbitration");
	endtask : t_arb

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	initial begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_receive;
		t_restart;
		t_arb;
		complete_run;
	end

	// a transfer takes under a thousand cycles; this allows many times that
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		err_total++;
		complete_run;
	end
endmodule : tw_master_rx_tb

bind tw_master_rx tw_master_rx_assertions i_chk (
	.sys_clk_in (sys_clk_in), .rst_in (rst_in),
	.wb_cyc_in (wb_cyc_in), .wb_stb_in (wb_stb_in),
	.wb_we_in (wb_we_in), .wb_adr_in (wb_adr_in),
	.wb_sel_in (wb_sel_in), .wb_dat_in (wb_dat_in),
	.wb_dat_out (wb_dat_out), .wb_ack_out (wb_ack_out),
	.scl_in (scl_in), .scl_out (scl_out), .scl_oe_out (scl_oe_out),
	.sda_in (sda_in), .sda_out (sda_out), .sda_oe_out (sda_oe_out)
);
`default_nettype wire
